/* File: verilog/tli_handler.sv */
// Two-level interrupt handler with APB register file
//
// Contract
// - Source event sets its pending flag
// - Request needs pending, own enable, global enable
// - Finish instruction, then long call to vector
// - Return resumes the interrupted program
// - Flags set regardless; disabled flags ignored
// - Some flags auto-clear; software clears others
// - Still-pending flag re-enters after one instruction
// - Per-source enable in basic or extended register
// - Global enable bit 7 gates all sources
// - Disabled events stay pending until re-enabled
// - Software setting a flag acts as event
// - Per-source priority bit, resets to low
// - High preempts low; nothing preempts high
// - Higher level first, then fixed order
// - Requests sampled and decoded every cycle
// - Equal or lower waits past return plus one
`timescale 1ns/1ps
`default_nettype none
`include "tli_cfg.svh"

module tli_handler (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic [31:0]          prdata,
    output var  logic                 pready,
    output var  logic                 pslverr,
    input  wire tli_pkg::tli_src_type src_event,
    input  wire logic                 cpu_instr_done,
    input  wire logic                 cpu_return_from_interrupt_instr_done,
    output var  logic                 cpu_irq_req,
    output var  logic                 long_call_go,
    output var  tli_pkg::tli_vec_type long_call_vector,
    output var  logic                 irq
);
    import tli_pkg::*;

    // ****************************************
    // State
    // ****************************************
    tli_src_type pend_q;
    tli_src_type pend_d;
    logic [7:0]  ien_q;
    logic [`TLI_NUM_EXT-1:0] ienx_q;
    logic [`TLI_NUM_BASIC-1:0] prio_q;
    logic [`TLI_NUM_EXT-1:0] priox_q;
    logic [1:0]  insvc_q;
    logic [1:0]  insvc_d;
    logic        block_q;
    logic        block_d;
    logic        win_valid_q;
    logic        win_hi_q;
    tli_idx_type win_idx_q;
    logic        go_q;
    tli_vec_type vec_q;
    tli_ev_type  stat_q;
    tli_ev_type  stat_d;
    tli_ev_type  staten_q;
    logic [31:0] rdata_q;
    logic        slverr_q;

    // ****************************************
    // APB decode
    // ****************************************
    wire logic setup_ph = psel & ~penable;
    wire logic wr_en    = psel & penable & pwrite;
    wire logic hit_pend    = (paddr == `TLI_OFS_PEND);
    wire logic hit_pendclr = (paddr == `TLI_OFS_PENDCLR);
    wire logic hit_ien     = (paddr == `TLI_OFS_IEN);
    wire logic hit_ienx    = (paddr == `TLI_OFS_IENX);
    wire logic hit_prio    = (paddr == `TLI_OFS_PRIO);
    wire logic hit_priox   = (paddr == `TLI_OFS_PRIOX);
    wire logic hit_insvc   = (paddr == `TLI_OFS_INSVC);
    wire logic hit_stat    = (paddr == `TLI_OFS_STAT);
    wire logic hit_statclr = (paddr == `TLI_OFS_STATCLR);
    wire logic hit_staten  = (paddr == `TLI_OFS_STATEN);
    wire logic hit_any = hit_pend | hit_pendclr | hit_ien
                       | hit_ienx | hit_prio | hit_priox
                       | hit_insvc | hit_stat | hit_statclr
                       | hit_staten;

    // Read mux; write-only clear registers read as zero
    wire logic [31:0] rd_mux =
          hit_pend   ? 32'(pend_q)
        : hit_ien    ? 32'(ien_q)
        : hit_ienx   ? 32'(ienx_q)
        : hit_prio   ? 32'(prio_q)
        : hit_priox  ? 32'(priox_q)
        : hit_insvc  ? 32'(insvc_q)
        : hit_stat   ? 32'(stat_q)
        : hit_staten ? 32'(staten_q)
        : 32'h00000000;

    // Data is captured in setup, so no wait states are needed
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = slverr_q;

    // ****************************************
    // Enables, priorities and request qualification
    // ****************************************
    wire tli_src_type en_all =
        {ienx_q, ien_q[`TLI_NUM_BASIC-1:0]};
    wire tli_src_type hi_sel = {priox_q, prio_q};
    wire logic gie = ien_q[`TLI_GIE_BIT];

    // Pending flags stay latched when gated off
    wire tli_src_type req_all =
        pend_q & en_all & {`TLI_NUM_SRC{gie}};

    // A running high handler blocks all; a running low blocks low
    wire logic hi_ok = ~insvc_q[1];
    wire logic lo_ok = ~insvc_q[1] & ~insvc_q[0];

    wire tli_src_type req_hi = req_all & hi_sel & {`TLI_NUM_SRC{hi_ok}};
    wire tli_src_type req_lo = req_all & ~hi_sel & {`TLI_NUM_SRC{lo_ok}};

    logic        hi_valid;
    tli_idx_type hi_idx;
    logic        lo_valid;
    tli_idx_type lo_idx;

    tli_arbiter u_arb_hi (
        .req   (req_hi),
        .valid (hi_valid),
        .idx   (hi_idx)
    );

    tli_arbiter u_arb_lo (
        .req   (req_lo),
        .valid (lo_valid),
        .idx   (lo_idx)
    );

    // High level beats low; the arbiters apply the fixed order
    wire logic        win_valid = hi_valid | lo_valid;
    wire logic        win_hi    = hi_valid;
    wire tli_idx_type win_idx   = hi_valid ? hi_idx : lo_idx;

    // ****************************************
    // Vectoring and return
    // ****************************************
    // The go pulse cycle is excluded because the registered winner
    // is one cycle stale right after a take.
    wire logic take = cpu_instr_done & win_valid_q & ~block_q
                    & ~cpu_return_from_interrupt_instr_done & ~go_q;

    wire tli_vec_type vec_addr =
        `TLI_VEC_BASE + (tli_vec_type'(win_idx_q) << `TLI_VEC_SHIFT);

    function automatic tli_src_type idx_mask(input tli_idx_type i);
        idx_mask = tli_src_type'(1) << i;
    endfunction

    wire tli_src_type take_mask = idx_mask(win_idx_q);

    // Return clears the highest marker, the one that was running
    always_comb begin
        insvc_d = insvc_q;
        if (cpu_return_from_interrupt_instr_done) begin
            if (insvc_q[1]) begin
                insvc_d[1] = 1'b0;
            end else begin
                insvc_d[0] = 1'b0;
            end
        end else if (take) begin
            if (win_hi_q) begin
                insvc_d[1] = 1'b1;
            end else begin
                insvc_d[0] = 1'b1;
            end
        end
    end

    // After a return one further instruction must complete
    always_comb begin
        block_d = block_q;
        if (cpu_return_from_interrupt_instr_done) begin
            block_d = 1'b1;
        end else if (cpu_instr_done) begin
            block_d = 1'b0;
        end
    end

    // ****************************************
    // Pending flags
    // ****************************************
    wire tli_src_type sw_set =
        (wr_en & hit_pend) ? pwdata[`TLI_NUM_SRC-1:0] : '0;
    wire tli_src_type sw_clr =
        (wr_en & hit_pendclr) ? pwdata[`TLI_NUM_SRC-1:0] : '0;
    wire tli_src_type hw_clr =
        take ? (take_mask & `TLI_HWCLR_MASK) : '0;

    // Sets win over clears so no event is lost; no enable gating
    assign pend_d = (pend_q & ~sw_clr & ~hw_clr)
                  | src_event | sw_set;

    // ****************************************
    // Event status and interrupt line
    // ****************************************
    wire tli_ev_type ev_now = {cpu_return_from_interrupt_instr_done, take};
    wire tli_ev_type ev_clr =
        (wr_en & hit_statclr) ? pwdata[`TLI_NUM_EV-1:0] : '0;

    assign stat_d = (stat_q & ~ev_clr) | ev_now;
    assign irq    = |(stat_q & staten_q);

    // ****************************************
    // Outputs to the CPU
    // ****************************************
    assign cpu_irq_req      = win_valid_q & ~block_q;
    assign long_call_go     = go_q;
    assign long_call_vector = vec_q;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q   <= `TLI_RST_IEN;
            ienx_q  <= `TLI_RST_IENX;
            prio_q  <= `TLI_RST_PRIO;
            priox_q <= `TLI_RST_PRIOX;
        end else if (wr_en) begin
            if (hit_ien) begin
                ien_q <= pwdata[7:0];
            end
            if (hit_ienx) begin
                ienx_q <= pwdata[`TLI_NUM_EXT-1:0];
            end
            if (hit_prio) begin
                prio_q <= pwdata[`TLI_NUM_BASIC-1:0];
            end
            if (hit_priox) begin
                priox_q <= pwdata[`TLI_NUM_EXT-1:0];
            end
        end
    end

    // Winner registered every cycle: the detect cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_valid_q <= 1'b0;
            win_hi_q    <= 1'b0;
            win_idx_q   <= '0;
        end else begin
            win_valid_q <= win_valid;
            win_hi_q    <= win_hi;
            win_idx_q   <= win_idx;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insvc_q <= 2'h0;
            block_q <= 1'b0;
        end else begin
            insvc_q <= insvc_d;
            block_q <= block_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q  <= 1'b0;
            vec_q <= 16'h0000;
        end else begin
            go_q <= take;
            if (take) begin
                vec_q <= vec_addr;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q   <= '0;
            staten_q <= '0;
        end else begin
            stat_q <= stat_d;
            if (wr_en & hit_staten) begin
                staten_q <= pwdata[`TLI_NUM_EV-1:0];
            end
        end
    end

    // Read data and error are settled before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q  <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            rdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            slverr_q <= ~hit_any;
        end
    end
endmodule // tli_handler

`default_nettype wire

/* File: verilog/tli_cfg.svh */
// Offsets, field positions, reset values and counts of the interrupt handler
`ifndef TLI_CFG_SVH
`define TLI_CFG_SVH

// ****************************************
// Sources and vectors
// ****************************************
`define TLI_NUM_SRC      19
`define TLI_IDX_W        5
`define TLI_NUM_BASIC    7
`define TLI_NUM_EXT      12
`define TLI_VEC_BASE     16'h0003
`define TLI_VEC_SHIFT    3
`define TLI_HWCLR_MASK   19'h0000F

// ****************************************
// Register byte offsets
// ****************************************
`define TLI_OFS_PEND     8'h00
`define TLI_OFS_PENDCLR  8'h04
`define TLI_OFS_IEN      8'h08
`define TLI_OFS_IENX     8'h0C
`define TLI_OFS_PRIO     8'h10
`define TLI_OFS_PRIOX    8'h14
`define TLI_OFS_INSVC    8'h18
`define TLI_OFS_STAT     8'h1C
`define TLI_OFS_STATCLR  8'h20
`define TLI_OFS_STATEN   8'h24

// ****************************************
// Fields and reset values
// ****************************************
`define TLI_GIE_BIT      7
`define TLI_EV_VEC       0
`define TLI_EV_RET       1
`define TLI_NUM_EV       2
`define TLI_RST_IEN      8'h00
`define TLI_RST_IENX     12'h000
`define TLI_RST_PRIO     7'h00
`define TLI_RST_PRIOX    12'h000

`endif

/* File: verilog/tli_pkg.sv */
// Types shared by the interrupt handler modules
`include "tli_cfg.svh"

package tli_pkg;
    typedef logic [`TLI_NUM_SRC-1:0] tli_src_type;
    typedef logic [`TLI_IDX_W-1:0]   tli_idx_type;
    typedef logic [15:0]             tli_vec_type;
    typedef logic [`TLI_NUM_EV-1:0]  tli_ev_type;
endpackage

/* File: verilog/tli_arbiter.sv */
// Fixed-order arbiter: lowest source number wins
`timescale 1ns/1ps
`default_nettype none
`include "tli_cfg.svh"

module tli_arbiter (
    input  wire tli_pkg::tli_src_type req,
    output var  logic                 valid,
    output var  tli_pkg::tli_idx_type idx
);
    import tli_pkg::*;

    // Scan from the top so the lowest set index is left standing
    always_comb begin
        valid = 1'b0;
        idx   = '0;
        for (int i = `TLI_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx   = tli_idx_type'(i);
            end
        end
    end
endmodule // tli_arbiter

`default_nettype wire

/* File: dv/tli_handler_props.sv */
// Port checker of the interrupt handler
`timescale 1ns/1ps
`default_nettype none

module tli_handler_props (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [7:0]           paddr,
    input wire logic                 pslverr,
    input wire logic                 cpu_instr_done,
    input wire logic                 cpu_return_from_interrupt_instr_done,
    input wire logic                 cpu_irq_req,
    input wire logic                 long_call_go,
    input wire tli_pkg::tli_vec_type long_call_vector
);
    import tli_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ********
    // Sequences
    // ********
    sequence s_take;
        cpu_instr_done && cpu_irq_req && !cpu_return_from_interrupt_instr_done && !long_call_go;
    endsequence
    sequence s_return_from_interrupt_instr_idle;
        cpu_return_from_interrupt_instr_done ##1 !cpu_instr_done;
    endsequence

    a_take_call: assert property (s_take |=> long_call_go)
        else $error("no long call after take");
    a_call_cause: assert property (long_call_go |-> $past(cpu_irq_req)
        && $past(cpu_instr_done))
        else $error("long call without request");
    a_call_pulse: assert property (long_call_go |=> !long_call_go)
        else $error("long call wider than one cycle");
    a_vec_form: assert property (long_call_go |-> long_call_vector[2:0] == 3'h3
        && long_call_vector <= 16'h0093)
        else $error("vector off grid");
    a_vec_hold: assert property ($changed(long_call_vector) |-> long_call_go)
        else $error("vector moved without a call");
    a_return_from_interrupt_instr_block: assert property (cpu_return_from_interrupt_instr_done |=> !cpu_irq_req)
        else $error("request right after return");
    a_return_from_interrupt_instr_gap: assert property (s_return_from_interrupt_instr_idle |=> !cpu_irq_req)
        else $error("request before next instruction");
    a_return_from_interrupt_instr_wins: assert property (cpu_return_from_interrupt_instr_done |=> !long_call_go)
        else $error("call taken on a return");
    a_unmapped: assert property (psel && !penable && paddr > 8'h24
        && paddr[1:0] == 2'h0 |=> pslverr)
        else $error("unmapped access not flagged");
endmodule // tli_handler_props

bind tli_handler tli_handler_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
    .cpu_instr_done, .cpu_return_from_interrupt_instr_done, .cpu_irq_req, .long_call_go, .long_call_vector);

`default_nettype wire

/* File: dv/tli_cpu_model.sv */
// Core sequencer stand-in marking instruction and return boundaries
`timescale 1ns/1ps
`default_nettype none

module tli_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       long_call_go,
    input  wire logic       return_from_interrupt_instr_req,
    input  wire logic [3:0] gap,
    output var  logic       cpu_instr_done,
    output var  logic       cpu_return_from_interrupt_instr_done
);
    logic [3:0] cnt_q;
    logic       end_w;

    // No boundary while the long call starts; gap of at least 1 keeps returns apart
    assign end_w = (cnt_q >= gap) && !long_call_go;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q          <= 4'h0;
            cpu_instr_done <= 1'b0;
            cpu_return_from_interrupt_instr_done  <= 1'b0;
        end else begin
            cnt_q          <= end_w ? 4'h0 : cnt_q + 4'h1;
            cpu_instr_done <= end_w;
            cpu_return_from_interrupt_instr_done  <= end_w && return_from_interrupt_instr_req;
        end
    end
endmodule // tli_cpu_model

`default_nettype wire

/* File: dv/tli_handler_bench.sv */
// Self-checking bench of the interrupt handler
`timescale 1ns/1ps
`default_nettype none

module tli_handler_bench;
    import tli_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, return_from_interrupt_instr_req;
    logic        cpu_instr_done, cpu_return_from_interrupt_instr_done, cpu_irq_req, long_call_go;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  gap;
    tli_src_type src_event;
    tli_vec_type long_call_vector;
    logic [32:0] exp_r[$];
    tli_vec_type exp_v[$];
    int          miscompares, n_compared, seed, s, k;

    tli_handler dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_event, .cpu_instr_done, .cpu_return_from_interrupt_instr_done, .cpu_irq_req,
        .long_call_go, .long_call_vector, .irq);
    tli_cpu_model cpu (.pclk, .presetn, .long_call_go, .return_from_interrupt_instr_req, .gap, .cpu_instr_done,
        .cpu_return_from_interrupt_instr_done);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ********
    // Tasks
    // ********
    task chk(input logic [32:0] got, input logic [32:0] want);
        n_compared++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    task chk_vec(input tli_vec_type got, input tli_vec_type want);
        chk({17'h0, got}, {17'h0, want});
    endtask
    task chk_lvl(input logic got, input logic want);
        chk({32'h0, got}, {32'h0, want});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] want);
        exp_r.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask
    task pulse(input tli_src_type m);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
    endtask
    task wait_call;
        for (k = 0; k < 80 && long_call_go !== 1'b1; k++) @(posedge pclk);
        @(posedge pclk);
    endtask
    task return_from_interrupt_instr;
        return_from_interrupt_instr_req <= 1'b1;
        do @(posedge pclk); while (cpu_return_from_interrupt_instr_done !== 1'b1);
        return_from_interrupt_instr_req <= 1'b0;
    endtask
    task end_sim;
        chk(33'(exp_v.size() + exp_r.size()), 33'h0);
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_r.pop_front());
        if (long_call_go === 1'b1) chk_vec(long_call_vector, exp_v.pop_front());
    end

    // Some hundred times the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_sim;
    end

    // ********
    // Scenarios
    // ********
    initial begin
        seed = 72;
        presetn = 1'b0;
        {psel, penable, pwrite, return_from_interrupt_instr_req, paddr, pwdata, src_event} = '0;
        gap = 4'h2;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h08, 33'h0);
        rd(8'h10, 33'h0);
        rd(8'h14, 33'h0);
        rd(8'h28, 33'h1_0000_0000);
        chk_lvl(pready, 1'b1);
        $display("test reset done");
        apb(1'b1, 8'h24, 32'h3);
        apb(1'b1, 8'h08, 32'h20);
        pulse(19'h20);
        repeat (3) @(posedge pclk);
        chk_lvl(cpu_irq_req, 1'b0);
        rd(8'h00, 33'h20);
        exp_v = '{16'h002B, 16'h002B};
        apb(1'b1, 8'h08, 32'hA0);
        wait_call;
        rd(8'h18, 33'h1);
        chk_lvl(irq, 1'b1);
        apb(1'b1, 8'h20, 32'h3);
        chk_lvl(irq, 1'b0);
        return_from_interrupt_instr;
        wait_call;
        rd(8'h1C, 33'h3);
        apb(1'b1, 8'h04, 32'h20);
        return_from_interrupt_instr;
        rd(8'h18, 33'h0);
        $display("test gate done");
        for (int i = 0; i < 3; i++) begin
            s = 7 + $unsigned($random(seed)) % 12;
            gap <= 4'($unsigned($random(seed)) % 4 + 1);
            apb(1'b1, 8'h0C, 32'h1 << (s - 7));
            exp_v.push_back(16'h0003 + 16'(s * 8));
            apb(1'b1, 8'h00, 32'h1 << s);
            wait_call;
            apb(1'b1, 8'h04, 32'h1 << s);
            return_from_interrupt_instr;
        end
        $display("test soft done");
        apb(1'b1, 8'h08, 32'hC4);
        apb(1'b1, 8'h10, 32'h40);
        exp_v = '{16'h0033, 16'h0013, 16'h0033};
        pulse(19'h44);
        wait_call;
        repeat (8) @(posedge pclk);
        rd(8'h18, 33'h2);
        apb(1'b1, 8'h04, 32'h40);
        return_from_interrupt_instr;
        wait_call;
        rd(8'h00, 33'h0);
        pulse(19'h40);
        wait_call;
        rd(8'h18, 33'h3);
        apb(1'b1, 8'h04, 32'h40);
        return_from_interrupt_instr;
        rd(8'h18, 33'h1);
        $display("test prio done");
        end_sim;
    end
endmodule // tli_handler_bench

`default_nettype wire
